// File: design/ieu_core.sv
// interrupt and exception unit: arbitration, nmi latching, acknowledge cycle, apb registers
//
// Overview of operation
// - nmi always uses vector 2 and runs no acknowledge cycle
// - nmi is serviced before a maskable interrupt pending at the same boundary
// - nmi blocked until interrupt return; one further edge latched and serviced later
// - unmasked maskable interrupt still serviced while nmi handler runs
// - halt inside nmi handler woken only by reset, maskable or management interrupt
// - writing one to bit 2 of config register seven raises a software nmi
// - maskable request honoured only while interrupt enable flag bit 9 is set
// - maskable interrupts taken between instructions or in string move gaps
// - maskable interrupt runs an acknowledge cycle reading an 8-bit vector
// - management interrupt outranks all others and bypasses the descriptor table
// - traps reported after the causing instruction completes
// - numbered software interrupt enters its handler whatever the enable flag holds
// - single step flag bit 8 raises debug vector 1 after every instruction
// - faults reported before completion, saved pointer addresses the faulting instruction
// - data breakpoints and single step are traps, other debug causes faults
// - double fault on vector 8 is the only abort
// - servicing pushes pointer and flags, error code for some protected exceptions
// - vectors below 32 are fixed assignments, some reserved
// - illegal opcodes raise invalid opcode vector 6
// - entry located by vector: 4 bytes real mode, 8 bytes protected
// - table base register resets to base zero, limit 3FF
// - interrupt gate clears enable flag; in protected mode trap gate keeps it, task gate switches; real mode always clears it
// - priority: management, debug traps, breakpoints, nmi, maskable, then faults
`timescale 1ns/1ps
module ieu_core
  import ieu_pkg::*;
(
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ieu_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // core state
  input  wire logic [31:0]          cpu_flags_reg,
  input  wire logic                 prot_mode,
  input  wire logic                 instr_done,
  input  wire logic                 string_gap,
  input  wire logic                 halt_exec,
  input  wire logic                 irq_return_instr_exec,
  // event sources
  input  wire logic                 mgmt_irq_n,
  input  wire logic                 maskable_irq_req,
  input  wire logic                 data_bp_hit,
  input  wire logic                 instr_bp_hit,
  input  wire logic                 illegal_op,
  input  wire logic                 exc_valid,
  input  wire logic [7:0]           exc_vector,
  input  wire logic                 soft_int_valid,
  input  wire logic [7:0]           soft_int_vector,
  // acknowledge cycle to the external controller
  output logic                      inta_req,
  input  wire logic                 inta_done,
  input  wire logic [7:0]           inta_vector,
  // service outputs
  output logic                      svc_valid,
  output ieu_pkg::ieu_svc_s         svc,
  output logic      [31:0]          desc_addr,
  output logic                      mgmt_entry,
  output logic                      halted,
  // gate handling after the descriptor is read
  input  wire logic                 gate_valid,
  input  wire ieu_pkg::ieu_gate_e   gate_type,
  output logic                      if_clear,
  output logic                      task_switch
);
  import ieu_pkg::*;

  ieu_state_e  state_r, state_nxt;
  ieu_svc_s    svc_r, svc_nxt;
  logic        svc_valid_r, svc_valid_nxt;
  logic [31:0] desc_r, desc_nxt;
  logic        mgmt_r, mgmt_nxt;
  logic        inta_req_r, inta_req_nxt;
  logic        nmi_pend_r, nmi_pend_nxt;
  logic        nmi_block_r, nmi_block_nxt;
  logic        smi_pend_r, smi_pend_nxt;
  logic        smi_prev_r, smi_prev_nxt;
  logic        if_clear_r, if_clear_nxt;
  logic        task_sw_r, task_sw_nxt;
  logic [31:0] vtb_base_r, vtb_base_nxt;
  logic [15:0] vtb_limit_r, vtb_limit_nxt;
  logic [7:0]  cfg7_r, cfg7_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        apb_setup, apb_wr, nmi_set, smi_take, nmi_take;
  logic        accept_pt, maskable_irq_req_ok, nmi_ok, dbg_trap;
  ieu_status_s status;

  // class of an exception vector raised by the core
  function automatic ieu_kind_e kind_of(input logic [7:0] v);
    if (v == VEC_BREAK || v == VEC_OVERFLOW) begin
      kind_of = K_TRAP;
    end else if (v == VEC_DOUBLE) begin
      kind_of = K_ABORT;
    end else begin
      kind_of = K_FAULT;
    end
  endfunction

  // build a service record
  function automatic ieu_svc_s mk_svc(input logic [7:0] v, input ieu_kind_e k,
                                      input ieu_src_e s, input logic pm);
    ieu_svc_s r;
    r.vector   = v;
    r.kind     = k;
    r.src      = s;
    r.push_err = pm && (s == SRC_EXC) &&
                 (v == VEC_DOUBLE || v == VEC_BADTASK || v == VEC_ABSENT ||
                  v == VEC_STACK || v == VEC_PROT || v == VEC_PAGE || v == VEC_ALIGN);
    r.restart  = (k == K_FAULT);
    mk_svc = r;
  endfunction

  // table entry address for a vector
  function automatic logic [31:0] desc_of(input logic [31:0] base, input logic [7:0] v,
                                          input logic pm);
    desc_of = pm ? base + (32'(v) << PROT_ENTRY_SHIFT) : base + (32'(v) << REAL_ENTRY_SHIFT);
  endfunction

  // qualifiers for arbitration
  always_comb begin
    accept_pt = instr_done | string_gap | (state_r == ST_HALT);
    maskable_irq_req_ok   = maskable_irq_req & cpu_flags_reg[FLAG_IF_BIT];
    nmi_ok    = nmi_pend_r & ~nmi_block_r;
    dbg_trap  = instr_done & (cpu_flags_reg[FLAG_TF_BIT] | data_bp_hit);
  end

  // arbitration and acknowledge sequencing
  always_comb begin
    state_nxt     = state_r;
    svc_nxt       = svc_r;
    svc_valid_nxt = 1'b0;
    desc_nxt      = desc_r;
    mgmt_nxt      = 1'b0;
    inta_req_nxt  = inta_req_r;
    smi_take      = 1'b0;
    nmi_take      = 1'b0;
    if (state_r == ST_ACK) begin
      if (inta_done) begin
        // vector read by the acknowledge cycle
        svc_nxt       = mk_svc(inta_vector, K_HWINT, SRC_MASKABLE_IRQ_REQ, prot_mode);
        svc_valid_nxt = 1'b1;
        desc_nxt      = desc_of(vtb_base_r, inta_vector, prot_mode);
        inta_req_nxt  = 1'b0;
        state_nxt     = ST_IDLE;
      end
    end else if (smi_pend_r) begin
      mgmt_nxt  = 1'b1;
      smi_take  = 1'b1;
      state_nxt = ST_IDLE;
    end else if (dbg_trap) begin
      svc_nxt       = mk_svc(VEC_DEBUG, K_TRAP, SRC_DBG, prot_mode);
      svc_valid_nxt = 1'b1;
      desc_nxt      = desc_of(vtb_base_r, VEC_DEBUG, prot_mode);
    end else if ((instr_done | string_gap) && instr_bp_hit) begin
      // execution breakpoint faults
      // only at a real boundary, so a held breakpoint never wakes a halt
      svc_nxt       = mk_svc(VEC_DEBUG, K_FAULT, SRC_DBG, prot_mode);
      svc_valid_nxt = 1'b1;
      desc_nxt      = desc_of(vtb_base_r, VEC_DEBUG, prot_mode);
    end else if (accept_pt && nmi_ok) begin
      svc_nxt       = mk_svc(VEC_NMI, K_HWINT, SRC_NMI, prot_mode);
      svc_valid_nxt = 1'b1;
      desc_nxt      = desc_of(vtb_base_r, VEC_NMI, prot_mode);
      nmi_take      = 1'b1;
      state_nxt     = ST_IDLE;
    end else if (accept_pt && maskable_irq_req_ok) begin
      // maskable served even in nmi handler
      inta_req_nxt = 1'b1;
      state_nxt    = ST_ACK;
    end else if (state_r == ST_HALT) begin
      state_nxt = ST_HALT;
    end else if (illegal_op) begin
      svc_nxt       = mk_svc(VEC_INVOP, K_FAULT, SRC_EXC, prot_mode);
      svc_valid_nxt = 1'b1;
      desc_nxt      = desc_of(vtb_base_r, VEC_INVOP, prot_mode);
    end else if (exc_valid) begin
      svc_nxt       = mk_svc(exc_vector, kind_of(exc_vector), SRC_EXC, prot_mode);
      svc_valid_nxt = 1'b1;
      desc_nxt      = desc_of(vtb_base_r, exc_vector, prot_mode);
    end else if (instr_done && soft_int_valid) begin
      svc_nxt       = mk_svc(soft_int_vector, K_TRAP, SRC_SOFT, prot_mode);
      svc_valid_nxt = 1'b1;
      desc_nxt      = desc_of(vtb_base_r, soft_int_vector, prot_mode);
    end else if (halt_exec) begin
      state_nxt = ST_HALT;
    end
  end

  // nmi and management latches
  always_comb begin
    apb_setup     = psel & ~penable;
    apb_wr        = psel & penable & pready_r & pwrite;
    nmi_set       = apb_wr && (paddr == OFS_CFG7) && pwdata[CFG7_NMI_BIT];
    nmi_pend_nxt  = nmi_set | (nmi_pend_r & ~nmi_take);
    nmi_block_nxt = nmi_take | (nmi_block_r & ~irq_return_instr_exec);
    smi_prev_nxt  = mgmt_irq_n;
    smi_pend_nxt  = (smi_prev_r & ~mgmt_irq_n) | (smi_pend_r & ~smi_take);
    if_clear_nxt  = gate_valid & ((gate_type == GATE_MASKABLE_IRQ_REQ) | ~prot_mode);
    task_sw_nxt   = gate_valid & prot_mode & (gate_type == GATE_TASK);
  end

  // apb register file: answer in the first access cycle
  always_comb begin
    status           = '0;
    status.state     = state_r;
    status.smi_pend  = smi_pend_r;
    status.nmi_pend  = nmi_pend_r;
    status.nmi_block = nmi_block_r;
    status.halted    = (state_r == ST_HALT);
    status.vector    = svc_r.vector;
    vtb_base_nxt     = vtb_base_r;
    vtb_limit_nxt    = vtb_limit_r;
    cfg7_nxt         = cfg7_r;
    pready_nxt       = apb_setup;
    prdata_nxt       = prdata_r;
    pslverr_nxt      = 1'b0;
    if (apb_setup) begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        OFS_VTB_BASE:  prdata_nxt = vtb_base_r;
        OFS_VTB_LIMIT: prdata_nxt = {16'h0000, vtb_limit_r};
        OFS_STATUS:    prdata_nxt = status;
        OFS_CFG7:      prdata_nxt = {24'h00_0000, cfg7_r};
        default:       pslverr_nxt = 1'b1;
      endcase
    end
    if (apb_wr) begin
      case (paddr)
        OFS_VTB_BASE:  vtb_base_nxt  = pwdata;
        OFS_VTB_LIMIT: vtb_limit_nxt = pwdata[15:0];
        OFS_CFG7:      cfg7_nxt      = pwdata[7:0];
        default:       cfg7_nxt      = cfg7_r;
      endcase
    end
  end

  // all state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= ST_IDLE;
      svc_r       <= '0;
      svc_valid_r <= 1'b0;
      desc_r      <= 32'h0000_0000;
      mgmt_r      <= 1'b0;
      inta_req_r  <= 1'b0;
      nmi_pend_r  <= 1'b0;
      nmi_block_r <= 1'b0;
      smi_pend_r  <= 1'b0;
      smi_prev_r  <= 1'b1;
      if_clear_r  <= 1'b0;
      task_sw_r   <= 1'b0;
      vtb_base_r  <= RST_VTB_BASE;
      vtb_limit_r <= RST_VTB_LIMIT;
      cfg7_r      <= RST_CFG7;
      prdata_r    <= 32'h0000_0000;
      pready_r    <= 1'b0;
      pslverr_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      svc_r       <= svc_nxt;
      svc_valid_r <= svc_valid_nxt;
      desc_r      <= desc_nxt;
      mgmt_r      <= mgmt_nxt;
      inta_req_r  <= inta_req_nxt;
      nmi_pend_r  <= nmi_pend_nxt;
      nmi_block_r <= nmi_block_nxt;
      smi_pend_r  <= smi_pend_nxt;
      smi_prev_r  <= smi_prev_nxt;
      if_clear_r  <= if_clear_nxt;
      task_sw_r   <= task_sw_nxt;
      vtb_base_r  <= vtb_base_nxt;
      vtb_limit_r <= vtb_limit_nxt;
      cfg7_r      <= cfg7_nxt;
      prdata_r    <= prdata_nxt;
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
    end
  end

  // outputs straight from flops
  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign inta_req    = inta_req_r;
  assign svc_valid   = svc_valid_r;
  assign svc         = svc_r;
  assign desc_addr   = desc_r;
  assign mgmt_entry  = mgmt_r;
  assign halted      = state_r[1]; // only the halt code has this state bit set
  assign if_clear    = if_clear_r;
  assign task_switch = task_sw_r;

  // checks on the arbitration
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_nmi_fixed;
    (svc_valid_r && svc_r.src == SRC_NMI) |-> (svc_r.vector == VEC_NMI) && !inta_req_r;
  endproperty
  a_nmi_fixed: assert property (p_nmi_fixed) else $error("nmi not on fixed vector");

  property p_nmi_first;
    (state_r == ST_IDLE && accept_pt && nmi_ok && maskable_irq_req_ok && !smi_pend_r && !dbg_trap
     && !instr_bp_hit) |=> svc_valid_r && svc_r.src == SRC_NMI && !inta_req_r;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("maskable beat nmi");

  property p_nmi_block;
    nmi_block_r |=> !(svc_valid_r && svc_r.src == SRC_NMI);
  endproperty
  a_nmi_block: assert property (p_nmi_block) else $error("nmi entered while blocked");

  property p_halt_nmi;
    (state_r == ST_HALT && nmi_block_r && !smi_pend_r && !maskable_irq_req_ok) |=> state_r == ST_HALT;
  endproperty
  a_halt_nmi: assert property (p_halt_nmi) else $error("halt left without wake");

  property p_maskable_irq_req_mask;
    (state_r != ST_ACK && !cpu_flags_reg[FLAG_IF_BIT]) |=> !$rose(inta_req_r);
  endproperty
  a_maskable_irq_req_mask: assert property (p_maskable_irq_req_mask) else $error("masked request acknowledged");

  property p_ack_vec;
    (state_r == ST_ACK && inta_done) |=> svc_valid_r && svc_r.vector == $past(inta_vector)
      && !inta_req_r;
  endproperty
  a_ack_vec: assert property (p_ack_vec) else $error("acknowledge vector lost");

  property p_smi_first;
    (state_r != ST_ACK && smi_pend_r) |=> mgmt_r && !svc_valid_r ##1 !mgmt_r;
  endproperty
  a_smi_first: assert property (p_smi_first) else $error("management not first");

  property p_step;
    (state_r != ST_ACK && instr_done && cpu_flags_reg[FLAG_TF_BIT] && !smi_pend_r)
      |=> svc_valid_r && svc_r.vector == VEC_DEBUG && svc_r.kind == K_TRAP;
  endproperty
  a_step: assert property (p_step) else $error("no step trap");

  property p_abort;
    (svc_valid_r && svc_r.src == SRC_EXC) |-> ((svc_r.kind == K_ABORT) ==
      (svc_r.vector == VEC_DOUBLE)) && (svc_r.restart == (svc_r.kind == K_FAULT));
  endproperty
  a_abort: assert property (p_abort) else $error("wrong exception class");

  property p_desc;
    svc_valid_r |-> desc_r == ($past(prot_mode) ?
      $past(vtb_base_r) + (32'(svc_r.vector) << PROT_ENTRY_SHIFT) :
      $past(vtb_base_r) + (32'(svc_r.vector) << REAL_ENTRY_SHIFT));
  endproperty
  a_desc: assert property (p_desc) else $error("entry address wrong");

  // main scenarios
  c_nmi:  cover property (svc_valid_r && svc_r.src == SRC_NMI);
  c_maskable_irq_req: cover property (state_r == ST_ACK ##[1:20] svc_valid_r);
  c_halt: cover property (state_r == ST_HALT ##[1:50] state_r == ST_ACK);
  c_smi:  cover property (mgmt_r);

endmodule

// File: design/ieu_pkg.sv
// package of constants, types and register map for the interrupt and exception unit
package ieu_pkg;

  // apb register map, byte addresses
  localparam int          ADDR_W        = 12;
  localparam logic [7:0]  CFG7_IDX      = 8'hEB;
  localparam logic [11:0] OFS_CFG7      = 12'({CFG7_IDX, 2'b00});
  localparam logic [11:0] OFS_VTB_BASE  = 12'h000;
  localparam logic [11:0] OFS_VTB_LIMIT = 12'h004;
  localparam logic [11:0] OFS_STATUS    = 12'h008;

  // values after reset
  localparam logic [31:0] RST_VTB_BASE  = 32'h0000_0000;
  localparam logic [15:0] RST_VTB_LIMIT = 16'h03FF;
  localparam logic [7:0]  RST_CFG7      = 8'h00;

  // bit positions
  localparam int CFG7_NMI_BIT = 2;
  localparam int FLAG_TF_BIT  = 8;
  localparam int FLAG_IF_BIT  = 9;

  // fixed vectors
  localparam logic [7:0] VEC_DIVIDE   = 8'h00;
  localparam logic [7:0] VEC_DEBUG    = 8'h01;
  localparam logic [7:0] VEC_NMI      = 8'h02;
  localparam logic [7:0] VEC_BREAK    = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW = 8'h04;
  localparam logic [7:0] VEC_BOUND    = 8'h05;
  localparam logic [7:0] VEC_INVOP    = 8'h06;
  localparam logic [7:0] VEC_NODEV    = 8'h07;
  localparam logic [7:0] VEC_DOUBLE   = 8'h08;
  localparam logic [7:0] VEC_BADTASK  = 8'h0A;
  localparam logic [7:0] VEC_ABSENT   = 8'h0B;
  localparam logic [7:0] VEC_STACK    = 8'h0C;
  localparam logic [7:0] VEC_PROT     = 8'h0D;
  localparam logic [7:0] VEC_PAGE     = 8'h0E;
  localparam logic [7:0] VEC_FPU      = 8'h10;
  localparam logic [7:0] VEC_ALIGN    = 8'h11;
  localparam logic [7:0] VEC_USER_MIN = 8'h20;

  // table entry sizes as shifts: 4 bytes real mode, 8 bytes protected
  localparam int REAL_ENTRY_SHIFT = 2;
  localparam int PROT_ENTRY_SHIFT = 3;

  typedef enum logic [1:0] {
    GATE_NONE = 2'b00,
    GATE_TASK = 2'b01,
    GATE_MASKABLE_IRQ_REQ = 2'b10,
    GATE_TRAP = 2'b11
  } ieu_gate_e;

  typedef enum logic [1:0] {
    K_TRAP  = 2'b00,
    K_FAULT = 2'b01,
    K_ABORT = 2'b10,
    K_HWINT = 2'b11
  } ieu_kind_e;

  typedef enum logic [2:0] {
    SRC_DBG  = 3'd0,
    SRC_NMI  = 3'd1,
    SRC_MASKABLE_IRQ_REQ = 3'd2,
    SRC_EXC  = 3'd3,
    SRC_SOFT = 3'd4
  } ieu_src_e;

  // gray coded along idle -> ack and idle -> halt
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK  = 2'b01,
    ST_HALT = 2'b10
  } ieu_state_e;

  typedef struct packed {
    logic [7:0] vector;
    ieu_kind_e  kind;
    ieu_src_e   src;
    logic       push_err;
    logic       restart;
  } ieu_svc_s;

  typedef struct packed {
    logic [17:0] pad;
    ieu_state_e  state;
    logic        smi_pend;
    logic        nmi_pend;
    logic        nmi_block;
    logic        halted;
    logic [7:0]  vector;
  } ieu_status_s;

endpackage

// File: tb/ieu_intc_model.sv
// behavioural external interrupt controller answering acknowledge cycles
`timescale 1ns/1ps
module ieu_intc_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // acknowledge handshake
  input  wire logic       inta_req,
  output logic            inta_done,
  output logic [7:0]      inta_vector,
  // bench control: vector to return and answer delay
  input  wire logic [7:0] ctl_vec,
  input  wire logic [3:0] ctl_wait
);
  logic [3:0] cnt_r;
  logic       served_r;
  // one answer per request; vector bus toggles when not answering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r       <= 4'h0;
      served_r    <= 1'b0;
      inta_done   <= 1'b0;
      inta_vector <= 8'h5A;
    end else begin
      inta_done   <= 1'b0;
      inta_vector <= ~inta_vector;
      if (!inta_req) begin
        cnt_r    <= 4'h0;
        served_r <= 1'b0;
      end else if (!served_r) begin
        if (cnt_r == ctl_wait) begin
          inta_done   <= 1'b1;
          inta_vector <= ctl_vec;
          served_r    <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
endmodule

// File: tb/ieu_core_tb.sv
// self-checking bench for the interrupt and exception unit
`timescale 1ns/1ps
module ieu_core_tb;
  import ieu_pkg::*;
  localparam logic [31:0] BASE = 32'h0000_1000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cpu_flags_reg, desc_addr, rd;
  logic        prot_mode, instr_done, string_gap, halt_exec, irq_return_instr_exec, mgmt_irq_n;
  logic        maskable_irq_req, data_bp_hit, instr_bp_hit, illegal_op, exc_valid;
  logic        soft_int_valid, inta_req, inta_done, svc_valid, mgmt_entry, halted;
  logic        gate_valid, if_clear, task_switch;
  logic [7:0]  exc_vector, soft_int_vector, inta_vector, ctl_vec;
  logic [3:0]  ctl_wait;
  ieu_svc_s    svc;
  ieu_gate_e   gate_type;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  // unit under test and acknowledge partner
  ieu_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cpu_flags_reg, .prot_mode, .instr_done, .string_gap, .halt_exec,
    .irq_return_instr_exec, .mgmt_irq_n, .maskable_irq_req, .data_bp_hit, .instr_bp_hit, .illegal_op,
    .exc_valid, .exc_vector, .soft_int_valid, .soft_int_vector, .inta_req, .inta_done,
    .inta_vector, .svc_valid, .svc, .desc_addr, .mgmt_entry, .halted, .gate_valid,
    .gate_type, .if_clear, .task_switch);
  ieu_intc_model i_intc (.pclk, .presetn, .inta_req, .inta_done, .inta_vector, .ctl_vec,
    .ctl_wait);

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // answer taken at the edge that samples pready, then released
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // instruction boundary, optionally an interrupt return
  task automatic boundary(input logic ret = 1'b0);
    @(posedge pclk);
    instr_done <= 1'b1;
    irq_return_instr_exec  <= ret;
    @(posedge pclk);
    instr_done <= 1'b0;
    irq_return_instr_exec  <= 1'b0;
  endtask
  task automatic expect_svc(input logic [7:0] v, input logic [1:0] k);
    int n;
    n = 0;
    #1;
    while (svc_valid !== 1'b1 && n < 40) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'({svc_valid, svc.vector, svc.kind}), 32'({1'b1, v, k}));
  endtask
  // nothing may be taken for c cycles
  task automatic quiet(input int c);
    repeat (c) begin
      #1;
      chk(32'({svc_valid, inta_req, mgmt_entry}), 32'h0);
      @(posedge pclk);
    end
  endtask

  task automatic s_regs();
    apb(1'b0, OFS_VTB_BASE, 32'h0);
    chk(rd, RST_VTB_BASE);
    apb(1'b0, OFS_VTB_LIMIT, 32'h0);
    chk(rd, 32'(RST_VTB_LIMIT));
    apb(1'b0, 12'hFF0, 32'h0);
    chk(32'({er, rd[7:0]}), 32'h100);
    apb(1'b1, OFS_VTB_BASE, BASE);
    apb(1'b0, OFS_VTB_BASE, 32'h0);
    chk(rd, BASE);
  endtask
  task automatic s_gates();
    ieu_gate_e  g [3] = '{GATE_MASKABLE_IRQ_REQ, GATE_TRAP, GATE_TASK};
    logic [1:0] e [3] = '{2'b10, 2'b00, 2'b01};
    logic [1:0] m [3] = '{2'b11, 2'b11, 2'b01};
    foreach (g[i]) begin
      @(posedge pclk);
      prot_mode  <= 1'b1;
      gate_valid <= 1'b1;
      gate_type  <= g[i];
      @(posedge pclk);
      gate_valid <= 1'b0;
      #1;
      chk(32'({if_clear, task_switch} & m[i]), 32'(e[i]));
    end
  endtask
  task automatic s_exc();
    int n;
    @(posedge pclk);
    cpu_flags_reg <= 32'h0000_0100;
    prot_mode     <= 1'b0;
    boundary();
    expect_svc(VEC_DEBUG, K_TRAP);
    chk(desc_addr, BASE + 32'h4);
    @(posedge pclk);
    cpu_flags_reg <= 32'h0;
    data_bp_hit   <= 1'b1;
    boundary();
    expect_svc(VEC_DEBUG, K_TRAP);
    // execution breakpoint is only taken at a boundary
    @(posedge pclk);
    data_bp_hit     <= 1'b0;
    instr_bp_hit    <= 1'b1;
    boundary();
    expect_svc(VEC_DEBUG, K_FAULT);
    @(posedge pclk);
    instr_bp_hit    <= 1'b0;
    soft_int_valid  <= 1'b1;
    soft_int_vector <= 8'h55;
    boundary();
    expect_svc(8'h55, K_TRAP);
    // core exceptions pulse once; a held one would be served again
    @(posedge pclk);
    soft_int_valid <= 1'b0;
    illegal_op     <= 1'b1;
    @(posedge pclk);
    illegal_op <= 1'b0;
    expect_svc(VEC_INVOP, K_FAULT);
    chk(32'(svc.restart), 32'h1);
    @(posedge pclk);
    prot_mode  <= 1'b1;
    exc_valid  <= 1'b1;
    exc_vector <= VEC_DOUBLE;
    @(posedge pclk);
    exc_valid <= 1'b0;
    expect_svc(VEC_DOUBLE, K_ABORT);
    chk(32'({svc.push_err, svc.restart}), 32'h2);
    chk(desc_addr, BASE + 32'h40);
    @(posedge pclk);
    exc_valid  <= 1'b1;
    exc_vector <= VEC_DIVIDE;
    @(posedge pclk);
    exc_valid <= 1'b0;
    expect_svc(VEC_DIVIDE, K_FAULT);
    // management edge is latched one cycle before the shared boundary
    @(posedge pclk);
    prot_mode        <= 1'b0;
    cpu_flags_reg    <= 32'h0000_0200;
    ctl_vec          <= 8'h9C;
    maskable_irq_req <= 1'b1;
    mgmt_irq_n       <= 1'b0;
    @(posedge pclk);
    instr_done <= 1'b1;
    @(posedge pclk);
    instr_done <= 1'b0;
    n = 0;
    #1;
    while (mgmt_entry !== 1'b1 && n < 8) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'({mgmt_entry, inta_req, svc_valid}), 32'h4);
    boundary();
    expect_svc(8'h9C, K_HWINT);
    @(posedge pclk);
    maskable_irq_req <= 1'b0;
    mgmt_irq_n       <= 1'b1;
  endtask
  task automatic s_mask();
    @(posedge pclk);
    cpu_flags_reg    <= 32'h0;
    maskable_irq_req <= 1'b1;
    ctl_vec          <= 8'h40;
    boundary();
    quiet(4);
    cpu_flags_reg <= 32'h0000_0200;
    prot_mode     <= 1'b1;
    quiet(4);
    string_gap <= 1'b1;
    @(posedge pclk);
    string_gap <= 1'b0;
    #1;
    chk(32'(inta_req), 32'h1);
    expect_svc(8'h40, K_HWINT);
    chk(desc_addr, BASE + 32'h200);
    @(posedge pclk);
    maskable_irq_req <= 1'b0;
    prot_mode        <= 1'b0;
  endtask
  task automatic s_nmi();
    @(posedge pclk);
    maskable_irq_req <= 1'b1;
    ctl_vec          <= 8'h41;
    apb(1'b1, OFS_CFG7, 32'h4);
    boundary();
    expect_svc(VEC_NMI, K_HWINT);
    chk(32'({svc.src, inta_req}), 32'({SRC_NMI, 1'b0}));
    chk(desc_addr, BASE + 32'h8);
    boundary();
    expect_svc(8'h41, K_HWINT);
    @(posedge pclk);
    maskable_irq_req <= 1'b0;
    apb(1'b1, OFS_CFG7, 32'h4);
    apb(1'b1, OFS_CFG7, 32'h4);
    boundary();
    quiet(3);
    // the latched edge is taken at the first boundary after the return
    boundary(1'b1);
    boundary();
    expect_svc(VEC_NMI, K_HWINT);
    boundary(1'b1);
    quiet(4);
  endtask
  task automatic s_halt();
    apb(1'b1, OFS_CFG7, 32'h4);
    boundary();
    expect_svc(VEC_NMI, K_HWINT);
    @(posedge pclk);
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    apb(1'b1, OFS_CFG7, 32'h4);
    quiet(4);
    #1;
    chk(32'(halted), 32'h1);
    // status: halt state, halted, nmi blocked and pending, last vector 2
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_2702);
    @(posedge pclk);
    ctl_vec          <= 8'hE7;
    maskable_irq_req <= 1'b1;
    expect_svc(8'hE7, K_HWINT);
    chk(32'(halted), 32'h0);
  endtask

  // reset, then the scenarios in turn
  initial begin
    {psel, penable, pwrite, prot_mode, instr_done, string_gap, halt_exec, irq_return_instr_exec,
     maskable_irq_req, data_bp_hit, instr_bp_hit, illegal_op, exc_valid, soft_int_valid,
     gate_valid, presetn} = '0;
    {paddr, pwdata, cpu_flags_reg, exc_vector, soft_int_vector, ctl_vec} = '0;
    gate_type  = GATE_NONE;
    mgmt_irq_n = 1'b1;
    ctl_wait   = 4'h3;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_gates();
    s_exc();
    s_mask();
    s_nmi();
    s_halt();
    end_of_test();
  end
endmodule
